// ### design/nsd_dac.sv
// Top of the noise-shaped PWM converter with its register port
`timescale 1ns/100ps
module nsd_dac
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [nsd_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [nsd_pkg::DATA_W-1:0] bus_wdata,
  input wire logic bus_write,
  input wire logic bus_read,
  output logic [nsd_pkg::DATA_W-1:0] bus_rdata,
  output logic pwm_out,
  output logic amp_enable,
  output logic amp_bandwidth
);
  import nsd_pkg::*;

  logic [DATA_W-1:0] in_low_reg, in_high_reg, cfg_main_reg, cfg_out_reg;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [CODE_W-1:0] code_reg;
  logic phase_reg, tick;
  logic pwm_out_reg, amp_en_reg, amp_bw_reg;
  logic [3:0] mod_width;
  logic [4:0] plain_shift;
  logic [PWM_W-1:0] shaper_code, pwm_code, pwm_count, plain_code, pwm_top;
  logic period_end, pwm_active;
  nsd_cfg_s cfg;

  // Registered outputs
  assign bus_rdata = rdata_reg;
  assign pwm_out = pwm_out_reg;
  assign amp_enable = amp_en_reg;
  assign amp_bandwidth = amp_bw_reg;

  // Configuration decode
  always_comb
  begin
    if (cfg_main_reg[ORDER_HI_POS])
      cfg.order = ORD_SECOND;
    else if (cfg_main_reg[ORDER_LO_POS])
      cfg.order = ORD_FIRST;
    else
      cfg.order = ORD_ZERO;
    cfg.pulse_resolution_sel = cfg_main_reg[RES_HI_POS:RES_LO_POS];
    cfg.amp_en = cfg_main_reg[AMP_EN_POS];
    cfg.dac_en = cfg_main_reg[DAC_EN_POS];
    cfg.fin_half = cfg_main_reg[FIN_POS];
    cfg.output_polarity_invert = cfg_out_reg[INV_POS];
    cfg.amplifier_bandwidth_sel = cfg_out_reg[BW_POS];
  end

  assign mod_width = MIN_WIDTH + {1'b0, cfg.pulse_resolution_sel};
  // Unshaped code, used as reference for the sequence checks
  assign plain_shift = 5'(CODE_W) - {1'b0, mod_width};
  assign plain_code = PWM_W'(code_reg >> plain_shift);
  assign pwm_top = PWM_W'((12'h001 << mod_width) - 12'h001);

  // data byte registers cleared by reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      in_low_reg <= REG_RESET;
      in_high_reg <= REG_RESET;
    end
    else if (bus_write && bus_addr == ADDR_IN_LOW)
      in_low_reg <= bus_wdata;
    else if (bus_write && bus_addr == ADDR_IN_HIGH)
      in_high_reg <= bus_wdata;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_main_reg <= REG_RESET;
      cfg_out_reg <= REG_RESET;
    end
    else if (bus_write && bus_addr == ADDR_CFG_MAIN)
      cfg_main_reg <= bus_wdata;
    else if (bus_write && bus_addr == ADDR_CFG_OUT)
      cfg_out_reg <= bus_wdata;
  end

  // transfer both bytes on high write
  // Low byte alone never disturbs the running code, so no torn values
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      code_reg <= CODE_RESET;
    else if (bus_write && bus_addr == ADDR_IN_HIGH)
      code_reg <= {bus_wdata, in_low_reg};
  end

  // Read mux, all four addresses mapped
  always_comb
  begin
    rdata_next = REG_RESET;
    if (bus_read)
    begin
      unique case (bus_addr)
        ADDR_IN_LOW: rdata_next = in_low_reg;
        ADDR_IN_HIGH: rdata_next = in_high_reg;
        ADDR_CFG_MAIN: rdata_next = cfg_main_reg;
        ADDR_CFG_OUT: rdata_next = cfg_out_reg;
      endcase
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_reg <= REG_RESET;
    else
      rdata_reg <= rdata_next;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      phase_reg <= 1'b0;
    else if (cfg.fin_half)
      phase_reg <= ~phase_reg;
    else
      phase_reg <= 1'b0;
  end

  // every edge at full rate, every second at half
  assign tick = !cfg.fin_half || phase_reg;

  nsd_shaper u_shaper
  (
    .clk(clk),
    .reset_n(reset_n),
    .step(period_end),
    .clear(!cfg.dac_en),
    .order(cfg.order),
    .width(mod_width),
    .in_code(code_reg),
    .out_code(shaper_code)
  );

  nsd_pwm u_pwm
  (
    .clk(clk),
    .reset_n(reset_n),
    .tick(tick),
    .run(cfg.dac_en),
    .width(mod_width),
    .next_code(shaper_code),
    .code(pwm_code),
    .count(pwm_count),
    .period_end(period_end),
    .active(pwm_active)
  );

  // polarity applied at the pin flop
  // disabled output rests at inactive level
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pwm_out_reg <= 1'b0;
    else if (cfg.dac_en)
      pwm_out_reg <= pwm_active ^ cfg.output_polarity_invert;
    else
      pwm_out_reg <= cfg.output_polarity_invert;
  end

  // amplifier controls registered to the pins
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      amp_en_reg <= 1'b0;
      amp_bw_reg <= 1'b0;
    end
    else
    begin
      amp_en_reg <= cfg.amp_en;
      amp_bw_reg <= cfg.amplifier_bandwidth_sel;
    end
  end

  // Checks on the converter behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  property p_low_no_effect;
    bus_write && bus_addr == ADDR_IN_LOW |=> code_reg == $past(code_reg);
  endproperty
  a_low_no_effect: assert property (p_low_no_effect)
    else $error("low byte write changed the converted code");

  property p_high_transfer;
    bus_write && bus_addr == ADDR_IN_HIGH
      |=> code_reg == {$past(bus_wdata), $past(in_low_reg)};
  endproperty
  a_high_transfer: assert property (p_high_transfer)
    else $error("high byte write did not load both bytes");

  property p_fin_full;
    !cfg.fin_half |-> tick;
  endproperty
  a_fin_full: assert property (p_fin_full)
    else $error("full-rate modulator missed a tick");

  property p_fin_half;
    (cfg.fin_half && tick) ##1 cfg.fin_half |-> !tick;
  endproperty
  a_fin_half: assert property (p_fin_half)
    else $error("half-rate modulator ticked twice in a row");

  property p_disabled_idle;
    !cfg.dac_en |=> pwm_out == $past(cfg.output_polarity_invert);
  endproperty
  a_disabled_idle: assert property (p_disabled_idle)
    else $error("disabled converter output not inactive");

  property p_active_level;
    cfg.dac_en && pwm_count < pwm_code
      |=> pwm_out == !$past(cfg.output_polarity_invert);
  endproperty
  a_active_level: assert property (p_active_level)
    else $error("output not active while count below code");

  property p_inactive_level;
    cfg.dac_en && pwm_count >= pwm_code
      |=> pwm_out == $past(cfg.output_polarity_invert);
  endproperty
  a_inactive_level: assert property (p_inactive_level)
    else $error("output active while count at or above code");

  property p_wrap;
    cfg.dac_en && tick && pwm_count == pwm_top && $stable(cfg_main_reg)
      |=> pwm_count == '0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("period counter did not wrap at two to the m");

  property p_one_code;
    period_end |=> pwm_code == $past(shaper_code);
  endproperty
  a_one_code: assert property (p_one_code)
    else $error("pwm period did not take the shaper code");

  property p_order_zero;
    period_end && cfg.order == ORD_ZERO |=> pwm_code == $past(plain_code);
  endproperty
  a_order_zero: assert property (p_order_zero)
    else $error("order zero code is not the truncated input");

  property p_bracket;
    period_end && cfg.order == ORD_FIRST
      |=> {1'b0, pwm_code} == {1'b0, $past(plain_code)}
        || {1'b0, pwm_code} == {1'b0, $past(plain_code)} + 12'h001;
  endproperty
  a_bracket: assert property (p_bracket)
    else $error("first order code outside the bracketing pair");

  property p_saturate;
    cfg.dac_en && $stable(cfg_main_reg) && !$rose(cfg.dac_en) |-> pwm_code <= pwm_top;
  endproperty
  a_saturate: assert property (p_saturate)
    else $error("shaper code beyond the m-bit range");

  property p_read_cfg;
    bus_read && bus_addr == ADDR_CFG_MAIN |=> bus_rdata == $past(cfg_main_reg);
  endproperty
  a_read_cfg: assert property (p_read_cfg)
    else $error("configuration read returned wrong data");

  property p_read_idle;
    !bus_read |=> bus_rdata == 8'h00;
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data not zero outside the read cycle");

  property p_amp_on;
    cfg.amp_en |=> amp_enable;
  endproperty
  a_amp_on: assert property (p_amp_on)
    else $error("amplifier enable pin did not follow its bit");

  property p_amp_off;
    !cfg.amp_en |=> !amp_enable;
  endproperty
  a_amp_off: assert property (p_amp_off)
    else $error("amplifier enable pin high while bit clear");

  property p_disabled_code;
    !cfg.dac_en |=> pwm_code == '0;
  endproperty
  a_disabled_code: assert property (p_disabled_code)
    else $error("disabled converter kept a pulse code");

  property p_disabled_shaper;
    !cfg.dac_en |=> u_shaper.e1_reg == '0 && u_shaper.e2_reg == '0;
  endproperty
  a_disabled_shaper: assert property (p_disabled_shaper)
    else $error("disabled converter kept shaper error memory");

  property p_hold_no_tick;
    cfg.dac_en && !tick |=> pwm_count == $past(pwm_count);
  endproperty
  a_hold_no_tick: assert property (p_hold_no_tick)
    else $error("period counter moved without a modulator tick");

  property p_low_store;
    bus_write && bus_addr == ADDR_IN_LOW |=> in_low_reg == $past(bus_wdata);
  endproperty
  a_low_store: assert property (p_low_store)
    else $error("low byte write not stored");

  property p_count_range;
    cfg.dac_en && $stable(cfg_main_reg) && !$rose(cfg.dac_en) |-> pwm_count <= pwm_top;
  endproperty
  a_count_range: assert property (p_count_range)
    else $error("period counter beyond two to the m steps");

  // Main scenarios
  c_second_order: cover property (period_end && cfg.order == ORD_SECOND);
  c_first_order: cover property (period_end && cfg.order == ORD_FIRST);
  c_half_rate: cover property (period_end && cfg.fin_half);
  c_inverted: cover property (cfg.dac_en && cfg.output_polarity_invert && pwm_active);
  c_high_write: cover property (bus_write && bus_addr == ADDR_IN_HIGH ##1 period_end);
endmodule

// ### design/nsd_pkg.sv
// Shared constants and types of the noise-shaped PWM converter
package nsd_pkg;
  // Register port geometry and register addresses
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam logic [1:0] ADDR_IN_LOW = 2'h0;
  localparam logic [1:0] ADDR_IN_HIGH = 2'h1;
  localparam logic [1:0] ADDR_CFG_MAIN = 2'h2;
  localparam logic [1:0] ADDR_CFG_OUT = 2'h3;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] CODE_RESET = 16'h0000;

  // Field positions in the main configuration register
  localparam int ORDER_HI_POS = 7;
  localparam int ORDER_LO_POS = 6;
  localparam int RES_HI_POS = 5;
  localparam int RES_LO_POS = 3;
  localparam int AMP_EN_POS = 2;
  localparam int DAC_EN_POS = 1;
  localparam int FIN_POS = 0;

  // Field positions in the output configuration register
  localparam int BW_POS = 1;
  localparam int INV_POS = 0;

  // Datapath sizes
  localparam int CODE_W = 16;
  localparam int PWM_W = 11;
  localparam int ERR_W = 20;
  localparam logic [3:0] MIN_WIDTH = 4'h4;

  typedef enum logic [1:0] {ORD_ZERO, ORD_FIRST, ORD_SECOND} nsd_order_e;

  // Decoded configuration handed to the datapath
  typedef struct packed {
    nsd_order_e order;
    logic [2:0] pulse_resolution_sel;
    logic amp_en;
    logic dac_en;
    logic fin_half;
    logic output_polarity_invert;
    logic amplifier_bandwidth_sel;
  } nsd_cfg_s;
endpackage

// ### design/nsd_shaper.sv
// Noise shaper of order zero, one or two with error feedback
`timescale 1ns/100ps
module nsd_shaper
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic step,
  input wire logic clear,
  input wire nsd_pkg::nsd_order_e order,
  input wire logic [3:0] width,
  input wire logic [nsd_pkg::CODE_W-1:0] in_code,
  output logic [nsd_pkg::PWM_W-1:0] out_code
);
  import nsd_pkg::*;

  logic [4:0] shift;
  logic signed [ERR_W-1:0] e1_reg, e2_reg, e1_next, e2_next;
  logic signed [ERR_W-1:0] acc, quant, qmax, resid, rmax;
  logic sat;

  // Quantise input plus weighted past errors to m bits
  always_comb
  begin
    shift = 5'(CODE_W) - {1'b0, width};
    qmax = (20'sd1 <<< width) - 20'sd1;
    rmax = (20'sd1 <<< shift) - 20'sd1;
    unique case (order)
      ORD_ZERO: acc = signed'({4'h0, in_code});
      ORD_FIRST: acc = signed'({4'h0, in_code}) + e1_reg;
      ORD_SECOND: acc = signed'({4'h0, in_code}) + (e1_reg <<< 1) - e2_reg;
      // Unused order code behaves as no shaping
      default: acc = signed'({4'h0, in_code});
    endcase
    quant = acc >>> shift;
    sat = 1'b0;
    if (quant > qmax)
    begin
      quant = qmax;
      sat = 1'b1;
    end
    else if (quant < 20'sd0)
    begin
      quant = 20'sd0;
      sat = 1'b1;
    end
    resid = acc - (quant <<< shift);
    // Saturated residue is bounded, else the loop would wind up
    if (sat && resid > rmax)
      resid = rmax;
    else if (sat && resid < 20'sd0)
      resid = 20'sd0;
    e1_next = resid;
    e2_next = sat ? resid : e1_reg;
  end

  assign out_code = quant[PWM_W-1:0];

  // error memory advances once per code
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      e1_reg <= 20'sd0;
      e2_reg <= 20'sd0;
    end
    else if (clear || order == ORD_ZERO)
    begin
      e1_reg <= 20'sd0;
      e2_reg <= 20'sd0;
    end
    else if (step)
    begin
      e1_reg <= e1_next;
      e2_reg <= e2_next;
    end
  end
endmodule

// ### design/nsd_pwm.sv
// PWM counter that emits one pulse per shaper code
`timescale 1ns/100ps
module nsd_pwm
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic run,
  input wire logic [3:0] width,
  input wire logic [nsd_pkg::PWM_W-1:0] next_code,
  output logic [nsd_pkg::PWM_W-1:0] code,
  output logic [nsd_pkg::PWM_W-1:0] count,
  output logic period_end,
  output logic active
);
  import nsd_pkg::*;

  logic [PWM_W-1:0] count_reg, code_reg, top;
  logic last;

  assign top = PWM_W'((12'h001 << width) - 12'h001);
  // A width cut mid-period ends the period at once
  assign last = count_reg >= top;
  assign period_end = run && tick && last;
  assign active = run && (count_reg < code_reg);
  assign code = code_reg;
  assign count = count_reg;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      count_reg <= '0;
    else if (!run)
      count_reg <= top;
    else if (tick)
      count_reg <= last ? '0 : count_reg + 11'h001;
  end

  // new code taken at each period start
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      code_reg <= '0;
    else if (!run)
      code_reg <= '0;
    else if (period_end)
      code_reg <= next_code;
  end
endmodule

// ### bench/nsd_filter_model.sv
// Stand-in for the external low-pass filter: integrates the PWM output
`timescale 1ns/100ps
module nsd_filter_model
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic pwm_in,
  input wire logic invert,
  input wire logic clear,
  output logic [15:0] active_cnt,
  output logic [15:0] last_len
);
  import nsd_pkg::*;
  logic active;
  logic [15:0] run_reg;

  // Active level depends on the polarity the bench selected
  assign active = pwm_in ^ invert;

  // Ideal integrator: one count per active cycle, restarted by clear
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      active_cnt <= 16'h0000;
    else if (clear)
      active_cnt <= {15'h0000, active};
    else
      active_cnt <= active_cnt + {15'h0000, active};
  end

  // Width of the last complete pulse, latched when it ends
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      run_reg <= 16'h0000;
      last_len <= 16'h0000;
    end
    else if (active)
      run_reg <= run_reg + 16'h0001;
    else
    begin
      if (run_reg != 16'h0000)
        last_len <= run_reg;
      run_reg <= 16'h0000;
    end
  end
endmodule

// ### bench/tb.sv
// Self-checking bench of the noise-shaped PWM converter
`timescale 1ns/100ps
module tb;
  import nsd_pkg::*;
  logic clk;
  logic reset_n;
  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] bus_wdata;
  logic bus_write;
  logic bus_read;
  logic [DATA_W-1:0] bus_rdata;
  logic pwm_out;
  logic amp_enable;
  logic amp_bandwidth;
  logic inv_sel;
  logic clr;
  logic [15:0] act;
  logic [15:0] last_len;
  int fail_count;
  int n_compared;

  nsd_dac DUT (.clk(clk), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata), .pwm_out(pwm_out),
    .amp_enable(amp_enable), .amp_bandwidth(amp_bandwidth));
  nsd_filter_model filt (.clk(clk), .reset_n(reset_n), .pwm_in(pwm_out), .invert(inv_sel),
    .clear(clr), .active_cnt(act), .last_len(last_len));

  // 20 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_write <= 1'b1;
    @(posedge clk);
    bus_write <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_read <= 1'b1;
    @(posedge clk);
    bus_read <= 1'b0;
    #1 d = bus_rdata;
  endtask

  // Count active cycles over a window of n clocks
  task automatic meas(input int n, output logic [15:0] c);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n - 1) @(posedge clk);
    #1 c = act;
  endtask

  function automatic logic [7:0] cfgm(input logic [1:0] o, input logic [2:0] r, input logic f);
    return {o, r, 2'b01, f};
  endfunction

  // Disable first so the shaper restarts from a cleared state
  task automatic go(input logic [7:0] m, input logic [7:0] o, input logic [15:0] code,
    input int settle);
    wr(ADDR_CFG_MAIN, 8'h00);
    inv_sel <= o[INV_POS];
    wr(ADDR_CFG_OUT, o);
    wr(ADDR_IN_LOW, code[7:0]);
    wr(ADDR_IN_HIGH, code[15:8]);
    wr(ADDR_CFG_MAIN, m);
    repeat (settle) @(posedge clk);
  endtask

  task automatic t_reset;
    logic [7:0] d;
    for (int a = 0; a < 4; a++)
    begin
      rd(a[1:0], d);
      chk("reg_reset", d, REG_RESET);
    end
    chk("idle_pins", {pwm_out, amp_enable, amp_bandwidth}, 3'h0);
  endtask

  task automatic t_regs;
    logic [7:0] d;
    wr(ADDR_CFG_OUT, 8'hfe);
    wr(ADDR_CFG_MAIN, 8'h04);
    rd(ADDR_CFG_OUT, d);
    chk("cfg_out_rb", d, 8'hfe);
    @(posedge clk);
    #1 chk("rdata_gone", bus_rdata, 8'h00);
    rd(ADDR_CFG_MAIN, d);
    chk("cfg_main_rb", d, 8'h04);
    chk("amp_pins", {amp_enable, amp_bandwidth, pwm_out}, 3'h6);
    wr(ADDR_CFG_OUT, 8'h01);
    repeat (2) @(posedge clk);
    chk("idle_inverted", pwm_out, 1'b1);
  endtask

  task automatic t_width;
    logic [15:0] c;
    int n;
    for (int r = 0; r < 8; r++)
    begin
      n = 1 << (4 + r);
      go(cfgm(2'b00, r[2:0], 1'b0), 8'h00, 16'ha5c3, 2 * n);
      meas(4 * n, c);
      chk("duty_width", c, 4 * (16'ha5c3 >> (12 - r)));
    end
  endtask

  task automatic t_dither;
    logic [15:0] c;
    go(cfgm(2'b00, 3'h0, 1'b0), 8'h00, 16'h5400, 64);
    meas(1024, c);
    chk("order_zero", c, 16'd320);
    go(cfgm(2'b01, 3'h0, 1'b0), 8'h00, 16'h5400, 64);
    meas(1024, c);
    chk("order_one", c, 16'd336);
    for (int o = 2; o < 4; o++)
    begin
      go(cfgm(o[1:0], 3'h0, 1'b0), 8'h00, 16'h5400, 128);
      meas(1024, c);
      chk("order_two", c >= 16'd332 && c <= 16'd340, 1'b1);
    end
    go(cfgm(2'b10, 3'h0, 1'b0), 8'h00, 16'h0400, 128);
    meas(1024, c);
    chk("order_two_low", c >= 16'd14 && c <= 16'd18, 1'b1);
  endtask

  task automatic t_sync;
    logic [15:0] c;
    go(cfgm(2'b01, 3'h4, 1'b0), 8'h00, 16'h1280, 512);
    meas(4096, c);
    chk("fine_code", c, 16'd296);
    wr(ADDR_IN_LOW, 8'h00);
    repeat (512) @(posedge clk);
    meas(4096, c);
    chk("low_alone", c, 16'd296);
    wr(ADDR_IN_HIGH, 8'h12);
    repeat (512) @(posedge clk);
    meas(4096, c);
    chk("high_commit", c, 16'd288);
  endtask

  task automatic t_rate;
    logic [15:0] c;
    go(cfgm(2'b00, 3'h0, 1'b1), 8'h00, 16'h4000, 64);
    meas(256, c);
    chk("half_duty", c, 16'd64);
    chk("half_pulse", last_len, 16'd8);
    go(cfgm(2'b00, 3'h0, 1'b0), 8'h01, 16'h4000, 64);
    meas(256, c);
    chk("inv_duty", c, 16'd64);
    chk("full_pulse", last_len, 16'd4);
    wr(ADDR_CFG_MAIN, 8'h00);
    meas(256, c);
    chk("off_quiet", c, 16'd0);
  endtask

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard well above the longest expected run
  initial
  begin
    #5000000;
    fail_count++;
    report_and_stop;
  end

  initial
  begin
    reset_n = 1'b0;
    bus_addr = '0;
    bus_wdata = '0;
    bus_write = 1'b0;
    bus_read = 1'b0;
    inv_sel = 1'b0;
    clr = 1'b0;
    fail_count = 0;
    n_compared = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_regs;
    t_width;
    t_dither;
    t_sync;
    t_rate;
    report_and_stop;
  end
endmodule
